// >>> tlp_pad_control.sv
// Contract
// - one pad config register at A4h
// - bit 28 selects supply pad drive
// - bits 27,23 set supply pad speed
// - bit 22 pull-up low, bit 21 pull-down
// - irq pad always filtered and enabled
// - bit 18 inverts irq input
// - bit 15 selects clock pad drive
// - bits 9,8 clock pad pull resistors
// - bit 7 selects data pad drive
// - bit 5 disables data input filter
// - bit 4 enables data pad receiver
// - bit 3 inverts data input
// - bits 1,0 data pad pull resistors
`timescale 1ns/100ps
module tlp_pad_control #(
  parameter int FILT_CYC = tlp_pkg::FILTER_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic scl_drive_val,
  input wire logic scl_drive_en,
  input wire logic sda_drive_val,
  input wire logic sda_drive_en,
  input wire logic tag_supply_on,
  output logic scl_level,
  output logic sda_level,
  output logic irq_level,
  input wire logic scl_pad_i,
  output logic scl_pad_o,
  output logic scl_pad_oe,
  output logic scl_pad_pullup,
  output logic scl_pad_pulldown,
  output logic [1:0] scl_pad_slew,
  input wire logic sda_pad_i,
  output logic sda_pad_o,
  output logic sda_pad_oe,
  output logic sda_pad_pullup,
  output logic sda_pad_pulldown,
  output logic [1:0] sda_pad_slew,
  input wire logic irq_pad_i,
  output logic supply_pad_o,
  output logic supply_pad_oe,
  output logic supply_pad_pullup_n,
  output logic supply_pad_pulldown,
  output logic [1:0] supply_pad_speed
);

  initial
  begin
    if (FILT_CYC < 1 || FILT_CYC > 255)
      $error("tlp_pad_control: FILT_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] cfg_reg, cfg_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0] status;
  logic cfg_sel;

  assign cfg_sel = (reg_addr == tlp_pkg::TAG_PAD_CONFIG_OFS);

  always_comb
  begin
    cfg_next = cfg_reg;
    if (reg_wr && cfg_sel)
    begin
      cfg_next = (reg_wdata & ~tlp_pkg::KEEP_MASK) | (cfg_reg & tlp_pkg::KEEP_MASK);
      cfg_next = cfg_next & ~tlp_pkg::UNUSED_MASK;
    end
  end

  // The read answer is registered so that it stands exactly one cycle after the strobe.
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (reg_rd)
    begin
      if (cfg_sel)
        rdata_next = cfg_reg & ~tlp_pkg::UNUSED_MASK;
      else if (reg_addr == tlp_pkg::TAG_PAD_STATUS_OFS)
        rdata_next = {29'h00000000, status};
      else
        rdata_next = 32'h00000000;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_reg <= tlp_pkg::TAG_PAD_CONFIG_RST;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Pad cells
  // ----------------------------------------------------------------
  tlp_pad_if clk_if();
  tlp_pad_if dat_if();
  tlp_pad_if irq_if();
  tlp_pad_if sup_if();

  assign clk_if.open_drain = cfg_reg[tlp_pkg::CLK_PAD_OPEN_DRAIN];
  assign clk_if.drive_val = scl_drive_val;
  assign clk_if.drive_en = scl_drive_en;
  assign clk_if.pin_i = scl_pad_i;
  assign clk_if.filt_off = cfg_reg[tlp_pkg::CLK_PAD_FILTER_DISABLE];
  assign clk_if.rx_on = cfg_reg[tlp_pkg::CLK_PAD_RECEIVER_ON];
  assign clk_if.invert = 1'b0;

  assign dat_if.open_drain = cfg_reg[tlp_pkg::DAT_PAD_OPEN_DRAIN];
  assign dat_if.drive_val = sda_drive_val;
  assign dat_if.drive_en = sda_drive_en;
  assign dat_if.pin_i = sda_pad_i;
  assign dat_if.filt_off = cfg_reg[tlp_pkg::DAT_PAD_FILTER_DISABLE];
  assign dat_if.rx_on = cfg_reg[tlp_pkg::DAT_PAD_RECEIVER_ON];
  assign dat_if.invert = cfg_reg[tlp_pkg::DAT_PAD_INVERT];

  // The interrupt cell ignores its two stored bits: it is hard-wired filtered and on.
  // irq always filtered, enabled
  assign irq_if.filt_off = 1'b0;
  assign irq_if.rx_on = 1'b1;
  assign irq_if.invert = cfg_reg[tlp_pkg::IRQ_PAD_INVERT];
  assign irq_if.pin_i = irq_pad_i;
  assign irq_if.open_drain = 1'b0;
  assign irq_if.drive_val = 1'b0;
  assign irq_if.drive_en = 1'b0;

  // The supply pad is output only; its drive enable is tied high, so outside reset only open drain releases it.
  // supply pad drive mode
  assign sup_if.open_drain = cfg_reg[tlp_pkg::TAG_SUPPLY_OPEN_DRAIN];
  assign sup_if.drive_val = tag_supply_on;
  assign sup_if.drive_en = 1'b1;
  assign sup_if.pin_i = 1'b0;
  assign sup_if.filt_off = 1'b0;
  assign sup_if.rx_on = 1'b0;
  assign sup_if.invert = 1'b0;

  tlp_pad_out u_clk_out (.mclk(mclk), .nrst(nrst), .pad(clk_if.tx));
  tlp_pad_out u_dat_out (.mclk(mclk), .nrst(nrst), .pad(dat_if.tx));
  tlp_pad_out u_sup_out (.mclk(mclk), .nrst(nrst), .pad(sup_if.tx));
  tlp_pad_in #(.FILT_CYC(FILT_CYC)) u_clk_in (.mclk(mclk), .nrst(nrst), .pad(clk_if.rx));
  tlp_pad_in #(.FILT_CYC(FILT_CYC)) u_dat_in (.mclk(mclk), .nrst(nrst), .pad(dat_if.rx));
  tlp_pad_in #(.FILT_CYC(FILT_CYC)) u_irq_in (.mclk(mclk), .nrst(nrst), .pad(irq_if.rx));

  assign scl_pad_o = clk_if.pad_o;
  assign scl_pad_oe = clk_if.pad_oe;
  assign sda_pad_o = dat_if.pad_o;
  assign sda_pad_oe = dat_if.pad_oe;
  assign supply_pad_o = sup_if.pad_o;
  assign supply_pad_oe = sup_if.pad_oe;
  assign scl_level = clk_if.level;
  assign sda_level = dat_if.level;
  assign irq_level = irq_if.level;

  always_comb
  begin
    status = 3'b000;
    status[tlp_pkg::STAT_CLK_LEVEL] = clk_if.level;
    status[tlp_pkg::STAT_DAT_LEVEL] = dat_if.level;
    status[tlp_pkg::STAT_IRQ_LEVEL] = irq_if.level;
  end

  // ----------------------------------------------------------------
  // Static pad controls
  // ----------------------------------------------------------------
  // supply pad speed
  assign supply_pad_speed = {cfg_reg[tlp_pkg::TAG_SUPPLY_SPEED_HI],
                             cfg_reg[tlp_pkg::TAG_SUPPLY_SPEED_LO]};
  assign supply_pad_pullup_n = cfg_reg[tlp_pkg::TAG_SUPPLY_PULLUP_N];
  assign supply_pad_pulldown = cfg_reg[tlp_pkg::TAG_SUPPLY_PULLDOWN];
  assign scl_pad_slew = {cfg_reg[tlp_pkg::CLK_PAD_SLEW_HI], cfg_reg[tlp_pkg::CLK_PAD_SLEW_LO]};
  assign scl_pad_pullup = cfg_reg[tlp_pkg::CLK_PAD_PULLUP];
  assign scl_pad_pulldown = cfg_reg[tlp_pkg::CLK_PAD_PULLDOWN];
  assign sda_pad_slew = {cfg_reg[tlp_pkg::DAT_PAD_SLEW_HI], cfg_reg[tlp_pkg::DAT_PAD_SLEW_LO]};
  assign sda_pad_pullup = cfg_reg[tlp_pkg::DAT_PAD_PULLUP];
  assign sda_pad_pulldown = cfg_reg[tlp_pkg::DAT_PAD_PULLDOWN];

endmodule // tlp_pad_control

// >>> tlp_pkg.sv
package tlp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] TAG_PAD_CONFIG_OFS = 12'h0A4;
  localparam logic [11:0] TAG_PAD_STATUS_OFS = 12'h100;
  localparam logic [31:0] TAG_PAD_CONFIG_RST = 32'h066F3333;
  // Bits that reads return as zero.
  localparam logic [31:0] UNUSED_MASK = 32'hE0000000;
  // Bits that a write never changes.
  localparam logic [31:0] KEEP_MASK = 32'h00030800;

  // ----------------------------------------------------------------
  // Field positions of tag_pad_config
  // ----------------------------------------------------------------
  localparam int TAG_SUPPLY_OPEN_DRAIN = 28;
  localparam int TAG_SUPPLY_SPEED_HI = 27;
  localparam int TAG_SUPPLY_SPEED_LO = 23;
  localparam int TAG_SUPPLY_PULLUP_N = 22;
  localparam int TAG_SUPPLY_PULLDOWN = 21;
  localparam int IRQ_PAD_FILTER_DISABLE = 20;
  localparam int IRQ_PAD_RECEIVER_ON = 19;
  localparam int IRQ_PAD_INVERT = 18;
  localparam int CLK_PAD_OPEN_DRAIN = 15;
  localparam int CLK_PAD_SLEW_HI = 14;
  localparam int CLK_PAD_FILTER_DISABLE = 13;
  localparam int CLK_PAD_RECEIVER_ON = 12;
  localparam int CLK_PAD_SLEW_LO = 10;
  localparam int CLK_PAD_PULLUP = 9;
  localparam int CLK_PAD_PULLDOWN = 8;
  localparam int DAT_PAD_OPEN_DRAIN = 7;
  localparam int DAT_PAD_SLEW_HI = 6;
  localparam int DAT_PAD_FILTER_DISABLE = 5;
  localparam int DAT_PAD_RECEIVER_ON = 4;
  localparam int DAT_PAD_INVERT = 3;
  localparam int DAT_PAD_SLEW_LO = 2;
  localparam int DAT_PAD_PULLUP = 1;
  localparam int DAT_PAD_PULLDOWN = 0;

  // Status register bit positions.
  localparam int STAT_CLK_LEVEL = 0;
  localparam int STAT_DAT_LEVEL = 1;
  localparam int STAT_IRQ_LEVEL = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 50;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> tlp_pad_if.sv
`timescale 1ns/100ps
interface tlp_pad_if;
  logic pin_i;
  logic filt_off;
  logic rx_on;
  logic invert;
  logic level;
  logic open_drain;
  logic drive_val;
  logic drive_en;
  logic pad_o;
  logic pad_oe;

  modport rx (input pin_i, input filt_off, input rx_on, input invert, output level);
  modport tx (input open_drain, input drive_val, input drive_en, output pad_o, output pad_oe);
  modport ctl (output pin_i, output filt_off, output rx_on, output invert, input level,
               output open_drain, output drive_val, output drive_en, input pad_o,
               input pad_oe);
endinterface // tlp_pad_if

// >>> tlp_pad_in.sv
`timescale 1ns/100ps
module tlp_pad_in #(
  parameter int FILT_CYC = tlp_pkg::FILTER_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  tlp_pad_if.rx pad
);

  initial
  begin
    if (FILT_CYC < 1 || FILT_CYC > 255)
      $error("tlp_pad_in: FILT_CYC out of range");
  end

  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic stable_reg, stable_next;
  logic [7:0] cnt_reg, cnt_next;
  logic level_reg, level_next;

  always_comb
  begin
    sync1_next = pad.pin_i;
    sync2_next = sync1_reg;
    stable_next = stable_reg;
    cnt_next = cnt_reg;
    // A change must hold for the whole filter time before it is taken.
    if (sync2_reg == stable_reg)
      cnt_next = 8'h00;
    else if (cnt_reg >= 8'(FILT_CYC - 1))
    begin
      stable_next = sync2_reg;
      cnt_next = 8'h00;
    end
    else
      cnt_next = cnt_reg + 8'h01;
    if (!pad.rx_on)
      level_next = 1'b0;
    else if (pad.filt_off)
      level_next = sync2_reg ^ pad.invert;
    else
      level_next = stable_reg ^ pad.invert;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      stable_reg <= 1'b0;
      cnt_reg <= 8'h00;
      level_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      stable_reg <= stable_next;
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign pad.level = level_reg;

endmodule // tlp_pad_in

// >>> tlp_pad_out.sv
`timescale 1ns/100ps
module tlp_pad_out (
  input wire logic mclk,
  input wire logic nrst,
  tlp_pad_if.tx pad
);

  logic o_reg, o_next;
  logic oe_reg, oe_next;

  // Simulated open drain only ever drives low; a high is left to the pull-up.
  always_comb
  begin
    if (pad.open_drain)
    begin
      o_next = 1'b0;
      oe_next = pad.drive_en & ~pad.drive_val;
    end
    else
    begin
      o_next = pad.drive_val;
      oe_next = pad.drive_en;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      o_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      o_reg <= o_next;
      oe_reg <= oe_next;
    end
  end

  assign pad.pad_o = o_reg;
  assign pad.pad_oe = oe_reg;

endmodule // tlp_pad_out

// >>> tlp_pad_control_asserts.sv
`timescale 1ns/100ps
module tlp_pad_control_asserts #(
  parameter int FILT_CYC = 5
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic scl_drive_val,
  input wire logic scl_drive_en,
  input wire logic sda_drive_val,
  input wire logic sda_drive_en,
  input wire logic tag_supply_on,
  input wire logic sda_level,
  input wire logic irq_level,
  input wire logic sda_pad_i,
  input wire logic irq_pad_i,
  input wire logic scl_pad_oe,
  input wire logic scl_pad_pullup,
  input wire logic scl_pad_pulldown,
  input wire logic sda_pad_o,
  input wire logic sda_pad_oe,
  input wire logic sda_pad_pullup,
  input wire logic sda_pad_pulldown,
  input wire logic supply_pad_o,
  input wire logic supply_pad_oe,
  input wire logic supply_pad_pullup_n,
  input wire logic supply_pad_pulldown,
  input wire logic [1:0] supply_pad_speed
);
  // --------
  // Shadow of the configuration word
  // --------
  logic [31:0] cfg_reg, cfg_next;
  logic wr_cfg;
  assign wr_cfg = reg_wr && reg_addr == 12'h0A4;
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_cfg)
      cfg_next = (reg_wdata & 32'h1FFCF7FF) | (cfg_reg & 32'h00030800);
  end
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      cfg_reg <= 32'h066F3333;
    else
      cfg_reg <= cfg_next;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Eight quiet cycles cover sync and filter only while FILT_CYC stays small.
  sequence s_irq_quiet;
    ($stable(irq_pad_i) && $stable(cfg_reg[18]))[*8];
  endsequence
  sequence s_sda_quiet;
    ($stable(sda_pad_i) && $stable(cfg_reg[5:3]))[*8];
  endsequence
  sequence s_irq_blip;
    $rose(irq_pad_i) ##1 $fell(irq_pad_i);
  endsequence
  a_read_back: assert property (reg_rd && reg_addr == 12'h0A4 |=>
    reg_rdata == $past(cfg_reg)) else $error("read data differs from config");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_pull_map: assert property ({scl_pad_pullup, scl_pad_pulldown, sda_pad_pullup,
    sda_pad_pulldown, supply_pad_pullup_n, supply_pad_pulldown} ==
    {cfg_reg[9:8], cfg_reg[1:0], cfg_reg[22:21]}) else $error("pull outputs wrong");
  a_speed_map: assert property (wr_cfg |=>
    supply_pad_speed == {$past(reg_wdata[27]), $past(reg_wdata[23])})
    else $error("supply speed wrong");
  a_scl_drive: assert property (1'h1 |=> scl_pad_oe == ($past(cfg_reg[15]) ?
    $past(scl_drive_en) && !$past(scl_drive_val) : $past(scl_drive_en)))
    else $error("clock pad enable wrong");
  a_sda_drive: assert property (1'h1 |=> {sda_pad_o, sda_pad_oe} == ($past(cfg_reg[7]) ?
    {1'h0, $past(sda_drive_en) && !$past(sda_drive_val)} :
    {$past(sda_drive_val), $past(sda_drive_en)})) else $error("data pad drive wrong");
  a_supply_drive: assert property (1'h1 |=> {supply_pad_o, supply_pad_oe} ==
    ($past(cfg_reg[28]) ? {1'h0, !$past(tag_supply_on)} : {$past(tag_supply_on), 1'h1}))
    else $error("supply pad drive wrong");
  a_irq_glitch: assert property (s_irq_blip |=> $stable(irq_level)[*6])
    else $error("irq glitch passed");
  a_irq_polarity: assert property (s_irq_quiet |-> irq_level == (irq_pad_i ^ cfg_reg[18]))
    else $error("irq level wrong");
  a_sda_level: assert property (s_sda_quiet |->
    sda_level == (cfg_reg[4] && (sda_pad_i ^ cfg_reg[3]))) else $error("data level wrong");
endmodule // tlp_pad_control_asserts

bind tlp_pad_control tlp_pad_control_asserts #(.FILT_CYC(FILT_CYC)) tlp_pad_control_asserts_i (.*);

// >>> tlp_tag_model.sv
`timescale 1ns/100ps
module tlp_tag_model (
  input wire logic mclk,
  input wire logic scl_pad_o,
  input wire logic scl_pad_oe,
  input wire logic scl_pad_pullup,
  input wire logic scl_pad_pulldown,
  input wire logic sda_pad_o,
  input wire logic sda_pad_oe,
  input wire logic sda_pad_pullup,
  input wire logic sda_pad_pulldown,
  input wire logic sda_hold_low,
  input wire logic irq_src,
  output logic scl_pad_i,
  output logic sda_pad_i,
  output logic irq_pad_i
);
  // --------
  // Wire resolution
  // --------
  // A line with no driver and no resistor toggles, so a floating pin never reads as a level.
  logic float_reg = 1'h0;
  always @(posedge mclk)
    float_reg <= !float_reg;
  assign scl_pad_i = scl_pad_oe ? scl_pad_o : scl_pad_pullup ? 1'h1 :
    scl_pad_pulldown ? 1'h0 : float_reg;
  assign sda_pad_i = sda_pad_oe ? sda_pad_o : sda_hold_low ? 1'h0 : sda_pad_pullup ? 1'h1 :
    sda_pad_pulldown ? 1'h0 : float_reg;
  assign irq_pad_i = irq_src;
endmodule // tlp_tag_model

// >>> test_tag_link_pad_control.sv
`timescale 1ns/100ps
module test_tag_link_pad_control;
  logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic scl_drive_val = 1'h0, scl_drive_en = 1'h0, sda_drive_val = 1'h0, sda_drive_en = 1'h0;
  logic tag_supply_on = 1'h0, sda_hold_low = 1'h0, irq_src = 1'h0;
  logic scl_level, sda_level, irq_level, scl_pad_i, sda_pad_i, irq_pad_i;
  logic scl_pad_o, scl_pad_oe, scl_pad_pullup, scl_pad_pulldown, sda_pad_o, sda_pad_oe;
  logic sda_pad_pullup, sda_pad_pulldown, supply_pad_o, supply_pad_oe;
  logic supply_pad_pullup_n, supply_pad_pulldown, po, pe;
  logic [1:0] scl_pad_slew, sda_pad_slew, supply_pad_speed, seen;
  int errors = 0, n_compared = 0;
  wire [5:0] pads = {scl_pad_o, scl_pad_oe, sda_pad_o, sda_pad_oe, supply_pad_o, supply_pad_oe};
  wire [5:0] pulls = {scl_pad_pullup, scl_pad_pulldown, sda_pad_pullup, sda_pad_pulldown,
    supply_pad_pullup_n, supply_pad_pulldown};
  wire [2:0] lvls = {scl_level, sda_level, irq_level};

  tlp_pad_control #(.FILT_CYC(2)) tlp_pad_control_i (.*);
  tlp_tag_model tlp_tag_model_i (.*);

  always #5 mclk = ~mclk;

  // --------
  // Bus and check tasks
  // --------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    @(posedge mclk);
  endtask
  // Read data lives one cycle only, so it is taken just after the answering edge.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'h1;
    reg_wr <= 1'h0;
    @(posedge mclk);
    #1 check(reg_rdata, exp);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The tests need a few hundred cycles; twenty microseconds means a hang.
  initial
  begin
    #20us;
    errors++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    idle(1);
    rd(12'h0A4, 32'h066F3333);
    rd(12'h0A8, 32'h0);
    wr(12'h0A4, 32'h1FEFF7FF);
    rd(12'h0A4, 32'h1FEFF7FF);
    check({26'h0, pulls}, 32'h3F);
    wr(12'h0A8, 32'h0);
    rd(12'h0A4, 32'h1FEFF7FF);
    wr(12'h0A4, 32'h000B3000);
    rd(12'h0A4, 32'h000B3000);
    check({26'h0, pulls}, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h0A4, {4'h0, i[1], 3'h0, i[0], 23'h0} | 32'h000B3000 |
        {17'h0, i[1], 3'h0, i[0], 3'h0, i[1], 3'h0, i[0], 2'h0});
      idle(1);
      check({30'h0, supply_pad_speed}, {30'h0, i[1:0]});
      check({26'h0, supply_pad_speed, scl_pad_slew, sda_pad_slew},
        {26'h0, {3{i[1:0]}}});
    end
    $display("test speed done");
    for (int m = 0; m < 8; m++)
    begin
      wr(12'h0A4, m[2] ? 32'h100BB080 : 32'h000B3000);
      {scl_drive_en, sda_drive_en} <= {2{m[1]}};
      {scl_drive_val, sda_drive_val, tag_supply_on} <= {3{m[0]}};
      idle(2);
      po = !m[2] && m[0];
      pe = m[2] ? !m[0] : 1'h1;
      check({26'h0, pads}, {26'h0, po, pe && m[1], po, pe && m[1], po, pe});
    end
    {scl_drive_en, sda_drive_en} <= 2'h0;
    $display("test drive done");
    for (int m = 0; m < 8; m++)
    begin
      wr(12'h0A4, 32'h000B3222 | {13'h0, m[1], 13'h0, m[2], m[1], 3'h0});
      sda_hold_low <= !m[0];
      irq_src <= m[0];
      idle(12);
      check({29'h0, lvls}, {29'h0, 1'h1, m[2] && (m[0] ^ m[1]), m[0] ^ m[1]});
      rd(12'h100, {29'h0, m[0] ^ m[1], m[2] && (m[0] ^ m[1]), 1'h1});
    end
    $display("test levels done");
    for (int f = 0; f < 2; f++)
    begin
      wr(12'h0A4, f ? 32'h000B3232 : 32'h000B3212);
      sda_hold_low <= 1'h0;
      irq_src <= 1'h0;
      idle(12);
      sda_hold_low <= 1'h1;
      irq_src <= 1'h1;
      @(posedge mclk);
      sda_hold_low <= 1'h0;
      irq_src <= 1'h0;
      seen = 2'h0;
      repeat (10)
      begin
        @(posedge mclk);
        seen = seen | {!sda_level, irq_level};
      end
      check({30'h0, seen}, {30'h0, f[0], 1'h0});
    end
    $display("test glitch done");
    finish_test();
  end
endmodule // test_tag_link_pad_control
